/* File: include/vwm_pkg.sv */
package vwm_pkg;
  // ---------------------------------------------------------------
  // object indices seen on the configuration port
  // ---------------------------------------------------------------
  localparam logic [15:0] OBJ_DWELL = 16'h606e;
  localparam logic [15:0] OBJ_LIMIT = 16'h606f;
  localparam logic [15:0] OBJ_LDWELL = 16'h6070;
  localparam logic [15:0] OBJ_SAVE = 16'h1010;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_DWELL = 16'h0000;
  localparam logic [15:0] RST_LIMIT = 16'h0064;
  localparam logic [15:0] RST_LDWELL = 16'h0000;
  // ---------------------------------------------------------------
  // internal drive parameter numbers and data set
  // ---------------------------------------------------------------
  localparam logic [10:0] PAR_DWELL = 11'h4fd;   // 1277
  localparam logic [10:0] PAR_LIMIT = 11'h4fe;   // 1278
  localparam logic [10:0] PAR_LDWELL = 11'h4ff;  // 1279
  localparam logic [2:0] PAR_DATA_SET = 3'h5;
  // save mask bit positions
  localparam int MSK_DWELL = 0;
  localparam int MSK_LIMIT = 1;
  localparam int MSK_LDWELL = 2;
  // status word bit positions
  localparam int STS_TARGET_BIT = 10;
  localparam int STS_LEVEL_BIT = 12;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* File: hw/vwm_qual_timer.sv */
`timescale 1ns/1ns
// counts millisecond ticks while a condition holds; done once limit is reached
module vwm_qual_timer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cond,
  input wire logic ms_tick,
  input wire logic [15:0] limit,
  output logic done
);
  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;

  // ---------------------------------------------------------------
  // tick counter
  // ---------------------------------------------------------------
  // saturates at 17'h1ffff, above the largest limit, so it never wraps back
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!cond) begin
      nxt_cnt = 17'h00000;
    end else if (ms_tick && cnt_ff != 17'h1ffff) begin
      nxt_cnt = cnt_ff + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_ff <= 17'h00000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done = cond && (cnt_ff >= {1'b0, limit});

  property p_restart;
    @(posedge ref_clk) disable iff (reset) !cond |=> cnt_ff == 17'h00000;
  endproperty
  a_restart: assert property (p_restart) else $error("timer did not restart");
endmodule

/* File: hw/vwm_monitor.sv */
`timescale 1ns/1ns
module vwm_monitor
  import vwm_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  output logic [15:0] obj_rdata,
  output logic obj_rvalid,
  output logic obj_rerr,
  input wire logic nv_restore_valid,
  input wire logic [15:0] nv_restore_index,
  input wire logic [15:0] nv_restore_data,
  output logic nv_save,
  output logic [2:0] nv_save_mask,
  output logic [15:0] nv_dwell,
  output logic [15:0] nv_limit,
  output logic [15:0] nv_ldwell,
  output logic param_wr,
  output logic [10:0] param_num,
  output logic [2:0] param_set,
  output logic [15:0] param_data,
  input wire logic speed_profile_mode,
  input wire logic [15:0] speed_window,
  input wire logic signed [31:0] target_speed,
  input wire logic signed [31:0] actual_speed,
  output logic target_reached,
  output logic speed_level,
  output logic [15:0] status_bits
);
  // magnitude of a 33-bit signed value, used for error and actual speed
  function automatic logic [32:0] abs33(input logic signed [32:0] v);
    abs33 = v[32] ? 33'(-v) : 33'(v);
  endfunction

  logic [15:0] dwell_ff, limit_ff, ldwell_ff;
  logic [15:0] nxt_dwell, nxt_limit, nxt_ldwell;
  logic [2:0] dirty_ff, nxt_dirty;
  logic save_ff, nxt_save;
  logic pwr_ff, nxt_pwr;
  logic [10:0] pnum_ff, nxt_pnum;
  logic [15:0] pdata_ff, nxt_pdata;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid, rerr_ff, nxt_rerr;
  logic [16:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  logic tr_ff, nxt_tr, lvl_ff, nxt_lvl;
  logic wr_en;
  logic [15:0] wr_idx, wr_data;
  logic [32:0] err_mag, act_mag;
  logic in_band, above, below, win_done, lvl_done;

  // ---------------------------------------------------------------
  // object writes and restore
  // ---------------------------------------------------------------
  // a restore at power-up takes the port; a master write that cycle is dropped
  assign wr_en = nv_restore_valid || obj_wr;
  assign wr_idx = nv_restore_valid ? nv_restore_index : obj_index;
  assign wr_data = nv_restore_valid ? nv_restore_data : obj_wdata;

  always_comb begin
    nxt_dwell = dwell_ff;
    nxt_limit = limit_ff;
    nxt_ldwell = ldwell_ff;
    nxt_dirty = dirty_ff;
    nxt_save = 1'b0;
    nxt_pwr = 1'b0;
    nxt_pnum = pnum_ff;
    nxt_pdata = pdata_ff;
    if (wr_en) begin
      case (wr_idx)
        OBJ_DWELL: begin
          nxt_dwell = wr_data;
          nxt_pwr = 1'b1;
          nxt_pnum = PAR_DWELL;
          nxt_pdata = wr_data;
          nxt_dirty[MSK_DWELL] = !nv_restore_valid;
        end
        OBJ_LIMIT: begin
          nxt_limit = wr_data;
          nxt_pwr = 1'b1;
          nxt_pnum = PAR_LIMIT;
          nxt_pdata = wr_data;
          nxt_dirty[MSK_LIMIT] = !nv_restore_valid;
        end
        OBJ_LDWELL: begin
          nxt_ldwell = wr_data;
          nxt_pwr = 1'b1;
          nxt_pnum = PAR_LDWELL;
          nxt_pdata = wr_data;
          nxt_dirty[MSK_LDWELL] = !nv_restore_valid;
        end
        OBJ_SAVE: begin
          // only objects the master touched since the last save are stored
          nxt_save = !nv_restore_valid;
          nxt_dirty = nv_restore_valid ? dirty_ff : 3'h0;
        end
        default: begin
          nxt_pwr = 1'b0;  // unmapped index: ignored
        end
      endcase
    end
  end

  // restored values also pass through the parameter mirror, so they win
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dwell_ff <= RST_DWELL;
      limit_ff <= RST_LIMIT;
      ldwell_ff <= RST_LDWELL;
      dirty_ff <= 3'h0;
      save_ff <= 1'b0;
      pwr_ff <= 1'b0;
      pnum_ff <= 11'h000;
      pdata_ff <= 16'h0000;
    end else begin
      dwell_ff <= nxt_dwell;
      limit_ff <= nxt_limit;
      ldwell_ff <= nxt_ldwell;
      dirty_ff <= nxt_dirty;
      save_ff <= nxt_save;
      pwr_ff <= nxt_pwr;
      pnum_ff <= nxt_pnum;
      pdata_ff <= nxt_pdata;
    end
  end

  // save mask is the dirty set captured at the save command
  logic [2:0] mask_ff, nxt_mask;
  assign nxt_mask = (nxt_save) ? dirty_ff : mask_ff;

  // ---------------------------------------------------------------
  // object reads
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rvalid = obj_rd;
    nxt_rerr = 1'b0;
    nxt_rdata = 16'h0000;
    if (obj_rd) begin
      case (obj_index)
        OBJ_DWELL: nxt_rdata = dwell_ff;
        OBJ_LIMIT: nxt_rdata = limit_ff;
        OBJ_LDWELL: nxt_rdata = ldwell_ff;
        default: nxt_rerr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      rerr_ff <= 1'b0;
      mask_ff <= 3'h0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      rerr_ff <= nxt_rerr;
      mask_ff <= nxt_mask;
    end
  end

  // ---------------------------------------------------------------
  // millisecond time base
  // ---------------------------------------------------------------
  always_comb begin
    nxt_tick = (tick_cnt_ff == 17'(MS_DIV - 1));
    nxt_tick_cnt = nxt_tick ? 17'h00000 : tick_cnt_ff + 17'h00001;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_cnt_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // ---------------------------------------------------------------
  // speed comparisons
  // ---------------------------------------------------------------
  // 33 bits so that the error of two extreme speeds cannot overflow
  assign err_mag = abs33(33'(target_speed) - 33'(actual_speed));
  assign act_mag = abs33(33'(actual_speed));
  // a zero band admits only an exact match
  assign in_band = (speed_window == 16'h0000) ? (err_mag == 33'h0) :
                   (err_mag < {17'h0, speed_window});
  assign above = speed_profile_mode && (act_mag > {17'h0, limit_ff});
  assign below = act_mag < {17'h0, limit_ff};

  vwm_qual_timer u_win_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .cond(in_band),
    .ms_tick(tick_ff),
    .limit(dwell_ff),
    .done(win_done)
  );

  vwm_qual_timer u_lvl_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .cond(above),
    .ms_tick(tick_ff),
    .limit(ldwell_ff),
    .done(lvl_done)
  );

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // level flag sets below the limit, keeps its value at the limit or while the level time runs above it; cleared out of mode
  always_comb begin
    nxt_tr = win_done;
    nxt_lvl = lvl_ff;
    if (!speed_profile_mode) begin
      nxt_lvl = 1'b0;
    end else if (below) begin
      nxt_lvl = 1'b1;
    end else if (lvl_done) begin
      nxt_lvl = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tr_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      tr_ff <= nxt_tr;
      lvl_ff <= nxt_lvl;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign obj_rdata = rdata_ff;
  assign obj_rvalid = rvalid_ff;
  assign obj_rerr = rerr_ff;
  assign nv_save = save_ff;
  assign nv_save_mask = mask_ff;
  assign nv_dwell = dwell_ff;
  assign nv_limit = limit_ff;
  assign nv_ldwell = ldwell_ff;
  assign param_wr = pwr_ff;
  assign param_num = pnum_ff;
  assign param_set = PAR_DATA_SET;
  assign param_data = pdata_ff;
  assign target_reached = tr_ff;
  assign speed_level = lvl_ff;
  always_comb begin
    status_bits = 16'h0000;
    status_bits[STS_TARGET_BIT] = tr_ff;
    status_bits[STS_LEVEL_BIT] = lvl_ff;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_dwell_wr;
    obj_wr && !nv_restore_valid && obj_index == OBJ_DWELL;
  endsequence
  sequence s_save_cmd;
    obj_wr && !nv_restore_valid && obj_index == OBJ_SAVE;
  endsequence

  property p_tr_set;
    @(posedge ref_clk) disable iff (reset) win_done |=> tr_ff;
  endproperty
  a_tr_set: assert property (p_tr_set) else $error("target flag not set");
  property p_tr_clr;
    @(posedge ref_clk) disable iff (reset) !in_band |=> !tr_ff;
  endproperty
  a_tr_clr: assert property (p_tr_clr) else $error("target flag not cleared");
  property p_band_zero;
    @(posedge ref_clk) disable iff (reset)
      (speed_window == 16'h0000 && target_speed != actual_speed) |-> !in_band;
  endproperty
  a_band_zero: assert property (p_band_zero) else $error("zero band accepted error");
  property p_lvl_set;
    @(posedge ref_clk) disable iff (reset) (speed_profile_mode && below) |=> lvl_ff;
  endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("level flag not set");
  property p_lvl_clr;
    @(posedge ref_clk) disable iff (reset)
      (speed_profile_mode && lvl_done && !below) |=> !lvl_ff;
  endproperty
  a_lvl_clr: assert property (p_lvl_clr) else $error("level flag not cleared");
  property p_lvl_mode;
    @(posedge ref_clk) disable iff (reset) !speed_profile_mode |=> !lvl_ff;
  endproperty
  a_lvl_mode: assert property (p_lvl_mode) else $error("level flag outside mode");
  property p_mirror_dwell;
    @(posedge ref_clk) disable iff (reset)
      s_dwell_wr |=> pwr_ff && pnum_ff == PAR_DWELL && pdata_ff == $past(obj_wdata);
  endproperty
  a_mirror_dwell: assert property (p_mirror_dwell) else $error("dwell not mirrored");
  property p_mirror_limit;
    @(posedge ref_clk) disable iff (reset)
      (obj_wr && !nv_restore_valid && obj_index == OBJ_LIMIT)
      |=> pwr_ff && pnum_ff == PAR_LIMIT && limit_ff == $past(obj_wdata);
  endproperty
  a_mirror_limit: assert property (p_mirror_limit) else $error("limit not mirrored");
  property p_save;
    @(posedge ref_clk) disable iff (reset)
      s_dwell_wr ##1 s_save_cmd |=> nv_save && nv_save_mask[MSK_DWELL];
  endproperty
  a_save: assert property (p_save) else $error("dwell not saved");
  property p_limit_rst;
    @(posedge ref_clk) $fell(reset) |-> limit_ff == RST_LIMIT;
  endproperty
  a_limit_rst: assert property (p_limit_rst) else $error("limit reset wrong");
endmodule

/* File: dv/vwm_master.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// fieldbus master side of the object port
// ---------------------------------------------------------------
// strobes change on the falling edge only; index and data are inverted when idle
// so the block can never pick up a stale word by accident
module vwm_master
  import vwm_pkg::*;
(
  input wire logic ref_clk,
  output logic obj_wr,
  output logic obj_rd,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata,
  input wire logic obj_rvalid,
  input wire logic obj_rerr
);
  initial begin
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end

  // one-cycle write strobe, taken at the rising edge in the middle
  task automatic wr(input logic [15:0] idx, input logic [15:0] data);
    @(negedge ref_clk);
    obj_wr = 1'b1;
    obj_index = idx;
    obj_wdata = data;
    @(negedge ref_clk);
    obj_wr = 1'b0;
    obj_index = ~idx;
    obj_wdata = ~data;
  endtask

  // two writes back to back; the strobe stays up across the middle edge
  task automatic wr2(input logic [15:0] idx0, input logic [15:0] data0,
                     input logic [15:0] idx1, input logic [15:0] data1);
    @(negedge ref_clk);
    obj_wr = 1'b1;
    obj_index = idx0;
    obj_wdata = data0;
    @(negedge ref_clk);
    obj_index = idx1;
    obj_wdata = data1;
    @(negedge ref_clk);
    obj_wr = 1'b0;
    obj_index = ~idx1;
    obj_wdata = ~data1;
  endtask

  // answer stands one cycle only, so it is sampled in that cycle
  task automatic rd(input logic [15:0] idx, output logic [15:0] data, output logic err);
    @(negedge ref_clk);
    obj_rd = 1'b1;
    obj_index = idx;
    @(negedge ref_clk);
    obj_rd = 1'b0;
    obj_index = ~idx;
    data = obj_rvalid ? obj_rdata : 16'hxxxx;
    err = obj_rvalid ? obj_rerr : 1'bx;
  endtask

  // store command; any data word is accepted
  task automatic save();
    wr(OBJ_SAVE, 16'h0000);
  endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
  import vwm_pkg::*;
  // ---------------------------------------------------------------
  // signals and tables
  // ---------------------------------------------------------------
  localparam int DIV = 10;
  localparam logic [15:0] IDX_TAB [3] = '{OBJ_DWELL, OBJ_LIMIT, OBJ_LDWELL};
  localparam logic [10:0] PAR_TAB [3] = '{PAR_DWELL, PAR_LIMIT, PAR_LDWELL};
  localparam logic [15:0] FIN_TAB [3] = '{16'h0002, 16'h0064, 16'h0001};
  logic ref_clk, reset, obj_wr, obj_rd, obj_rvalid, obj_rerr, nv_save, param_wr;
  logic nvr_valid, mode, target_reached, speed_level, err;
  logic [15:0] obj_index, obj_wdata, obj_rdata, nvr_index, nvr_data, window, status_bits;
  logic [15:0] nv_dwell, nv_limit, nv_ldwell, param_data, rdata, v;
  logic [10:0] param_num;
  logic [2:0] nv_save_mask, param_set;
  logic signed [31:0] target, actual;
  int error_cnt, total_checks;

  vwm_monitor #(.MS_DIV(DIV)) uut (
    .ref_clk(ref_clk), .reset(reset), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_rvalid(obj_rvalid), .obj_rerr(obj_rerr), .nv_restore_valid(nvr_valid),
    .nv_restore_index(nvr_index), .nv_restore_data(nvr_data), .nv_save(nv_save),
    .nv_save_mask(nv_save_mask), .nv_dwell(nv_dwell), .nv_limit(nv_limit),
    .nv_ldwell(nv_ldwell), .param_wr(param_wr), .param_num(param_num),
    .param_set(param_set), .param_data(param_data), .speed_profile_mode(mode),
    .speed_window(window), .target_speed(target), .actual_speed(actual),
    .target_reached(target_reached), .speed_level(speed_level), .status_bits(status_bits)
  );

  vwm_master bus (
    .ref_clk(ref_clk), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid),
    .obj_rerr(obj_rerr)
  );

  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp, input logic e);
    bus.rd(idx, rdata, err);
    chk(rdata === exp && err === e, "object read");
  endtask

  // waits for a flag under a bound; tick phase is free so only a span is checked
  task automatic expect_flag(input int sel, input logic val, input int lo, input int hi);
    int n;
    logic f;
    n = 0;
    f = ~val;
    while (f !== val && n < hi) begin
      @(negedge ref_clk);
      n++;
      f = sel ? speed_level : target_reached;
    end
    chk(f === val && n >= lo && status_bits[sel ? STS_LEVEL_BIT : STS_TARGET_BIT] === val,
        "flag timing");
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the sequence needs well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    nvr_valid = 1'b0;
    nvr_index = 16'h0000;
    nvr_data = 16'h0000;
    mode = 1'b1;
    window = 16'h0000;
    target = 32'sh0;
    actual = 32'sh0;
    error_cnt = 0;
    total_checks = 0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    rd_chk(OBJ_DWELL, 16'h0000, 1'b0);
    rd_chk(OBJ_LIMIT, 16'h0064, 1'b0);
    rd_chk(OBJ_LDWELL, 16'h0000, 1'b0);
    rd_chk(16'h6071, 16'h0000, 1'b1);
    // full-scale words first, then the values the supervision tests use
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 3; i++) begin
        v = p ? FIN_TAB[i] : 16'hffff;
        bus.wr(IDX_TAB[i], v);
        chk(param_wr === 1'b1 && param_num === PAR_TAB[i] && param_set === 3'h5
            && param_data === v, "parameter mirror");
        rd_chk(IDX_TAB[i], v, 1'b0);
      end
    end
    bus.save();
    chk(nv_save === 1'b1 && nv_save_mask === 3'h7 && nv_dwell === 16'h0002
        && nv_limit === 16'h0064 && nv_ldwell === 16'h0001, "save");
    @(negedge ref_clk);
    chk(nv_save === 1'b0, "save pulse");
    // dwell then save on consecutive edges: only the dwell bit is stored
    bus.wr2(OBJ_DWELL, 16'h0002, OBJ_SAVE, 16'h0000);
    chk(nv_save === 1'b1 && nv_save_mask === 3'h1
        && nv_dwell === 16'h0002, "save mask");
    // band of 5 around 1000, dwell of two ticks
    window = 16'h0005;
    target = 32'sh3e8;
    expect_flag(0, 1'b0, 1, 1);
    actual = 32'sh3ec;
    expect_flag(0, 1'b1, 11, 22);
    actual = 32'sh3ed;
    expect_flag(0, 1'b0, 1, 1);
    actual = 32'sh3e4;
    expect_flag(0, 1'b1, 11, 22);
    bus.wr(OBJ_DWELL, 16'h0000);
    window = 16'h0000;
    actual = 32'sh3e9;
    expect_flag(0, 1'b0, 1, 1);
    actual = 32'sh3e8;
    expect_flag(0, 1'b1, 1, 1);
    // speed level against a limit of 100 with one tick of level time
    actual = -32'sh0032;
    expect_flag(1, 1'b1, 1, 1);
    actual = -32'sh00c8;
    expect_flag(1, 1'b0, 2, 12);
    actual = -32'sh0032;
    expect_flag(1, 1'b1, 1, 1);
    mode = 1'b0;
    expect_flag(1, 1'b0, 1, 1);
    // power-up again with a stored limit
    reset = 1'b1;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    nvr_valid = 1'b1;
    nvr_index = OBJ_LIMIT;
    nvr_data = 16'h00c8;
    @(negedge ref_clk);
    nvr_valid = 1'b0;
    nvr_index = ~OBJ_LIMIT;
    nvr_data = 16'hff37;
    chk(param_wr === 1'b1 && param_num === PAR_LIMIT
        && param_data === 16'h00c8, "restore override");
    rd_chk(OBJ_LIMIT, 16'h00c8, 1'b0);
    // a restored object is not dirty, so a save right after stores nothing
    bus.save();
    chk(nv_save === 1'b1 && nv_save_mask === 3'h0, "restore dirty");
    give_verdict();
  end
endmodule
